// file: wpms_chk.sv
// Assertion checker for the wake, power mode and reset sequencer
`timescale 1ns/100ps
module wpms_chk (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Thermal, event and strap inputs
  input wire temp_alert_hi,
  input wire temp_alert_lo,
  input wire temp_sd_hi,
  input wire wdog_reset,
  input wire cpu_reset,
  input wire security_reset,
  input wire otp_io_fw_ctrl,
  // Power and reset outputs
  input wire core_regulator_en,
  input wire analog_regulator_en,
  input wire io_regulator_1v8,
  input wire fast_oscillator_en,
  input wire afe_sleep,
  input wire slow_clk_mode,
  input wire cpu_run,
  input wire flash_on,
  input wire rom_on,
  input wire ram_retain,
  input wire mcu_reset,
  input wire fet_enable,
  input wire [1:0] pmu_mode
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  property p_one_mode;
    pmu_mode != 2'h3;
  endproperty
  a_one_mode: assert property (p_one_mode) else $error("mode code out of range");
  property p_stop_halt;
    pmu_mode == 2'h1 && $past(pmu_mode) == 2'h1 |-> !cpu_run;
  endproperty
  a_stop_halt: assert property (p_stop_halt) else $error("cpu runs in stop");
  // Settled standby only, entry may take a cycle
  property p_standby;
    pmu_mode == 2'h2 && $past(pmu_mode) == 2'h2 |-> afe_sleep && !fast_oscillator_en
      && slow_clk_mode && !flash_on && !rom_on && ram_retain;
  endproperty
  a_standby: assert property (p_standby) else $error("standby outputs wrong");
  property p_alert;
    temp_alert_hi [*8] |-> mcu_reset && !core_regulator_en;
  endproperty
  a_alert: assert property (p_alert) else $error("alert did not stop core");
  property p_tsd;
    temp_sd_hi [*8] |-> mcu_reset && !core_regulator_en && !analog_regulator_en;
  endproperty
  a_tsd: assert property (p_tsd) else $error("shutdown left a regulator on");
  property p_hold_off;
    $fell(temp_alert_hi) ##1 temp_alert_lo [*7] |-> !core_regulator_en;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("core back above falling");
  property p_mcu_rst;
    wdog_reset || cpu_reset || security_reset |-> ##[1:8] mcu_reset;
  endproperty
  a_mcu_rst: assert property (p_mcu_rst) else $error("mcu reset missing");
  property p_cpu_local;
    cpu_reset |=> ($stable(analog_regulator_en) && $stable(core_regulator_en)) [*8];
  endproperty
  a_cpu_local: assert property (p_cpu_local) else $error("cpu reset hit regulators");
  property p_io_default;
    (!otp_io_fw_ctrl) [*4] |-> !io_regulator_1v8;
  endproperty
  a_io_default: assert property (p_io_default) else $error("io not at 3v3");
  property p_fet_last;
    $rose(fet_enable) |-> !mcu_reset && core_regulator_en && analog_regulator_en;
  endproperty
  a_fet_last: assert property (p_fet_last) else $error("fets before power up");
  c_fet: cover property ($rose(fet_enable));
  c_standby: cover property (pmu_mode == 2'h2);
  c_tsd: cover property (temp_sd_hi && !analog_regulator_en);
endmodule // wpms_chk

bind wpms_top wpms_chk u_chk (.clk_sys, .rstn, .temp_alert_hi, .temp_alert_lo, .temp_sd_hi,
  .wdog_reset, .cpu_reset, .security_reset, .otp_io_fw_ctrl, .core_regulator_en,
  .analog_regulator_en, .io_regulator_1v8, .fast_oscillator_en, .afe_sleep, .slow_clk_mode,
  .cpu_run, .flash_on, .rom_on, .ram_retain, .mcu_reset, .fet_enable, .pmu_mode);

// file: wpms_defs.vh
// Constants for the wake, power mode and reset sequencer
// Summary of operation
// - Sleep or hibernate wakes on GPIO, comms or RTC timer event
// - Shutdown or shelf wakes only on wake input or pack voltage detect
// - Wake input pulled low leaves shutdown or shelf
// - Shutdown wake: regulators, MCU init, settings, measure, check, then FETs
// - Optional automatic return to shelf after programmed minutes
// - Exactly one of run, stop, standby active as a state machine
// - Run allows all; firmware may switch off flash, RAM, ROM
// - Stop halts CPU; flash, ROM may power off; RAM may retain
// - Standby asserts sleep to front end, stops fast clock, 32 kHz logic
// - Run for normal, stop for sleep, standby for hibernate/shutdown
// - Thermal alert resets MCU and disables core regulator until it falls
// - Thermal shutdown disables core and analog regulators in reset
// - After shutdown, analog regulator back below falling; sequence waits alert
// - IO regulator 3.3V unless OTP gives firmware choice via flash bit
// - External regulator selectable 2.5, 3.0, 3.3, 5.0 V
// - Pin triggers MCU or full reset; host reset needs firmware permission
// - MCU and watchdog resets keep diagnostics; front end reason cleared by POR/comms
// - Front end reset while supply low, release after stable reset time
// - Front end holds MCU reset for power-on reset duration
// - On release load trim, enable CPU, run ROM init, then flash
// - MCU reset from watchdog, CPU, security, or optional double error
// - CPU reset stays in MCU, no front end effect
// - Watchdog reset keeps reason register and user data
`ifndef WPMS_DEFS_VH
`define WPMS_DEFS_VH
`define WPMS_ADDR_CTRL 12'h000
`define WPMS_ADDR_MODE 12'h004
`define WPMS_ADDR_STATUS 12'h008
`define WPMS_ADDR_RESET 12'h00c
`define WPMS_ADDR_SHELF 12'h010
`define WPMS_ADDR_REASON 12'h014
`define WPMS_ADDR_USER 12'h018
`define WPMS_ADDR_REGSEL 12'h01c
`define WPMS_RST_TIME_US 100
`define WPMS_RST_POR_US 2000
`define WPMS_TRIM_CYC 16
`define WPMS_ROM_CYC 64
`define WPMS_STEP_CYC 32
`define WPMS_CLK_MHZ 40
`define WPMS_SLOW_DIV 1250
`define WPMS_MIN_TICKS 1920000
`define WPMS_REASON_POR 3'h1
`define WPMS_REASON_WDOG 3'h2
`define WPMS_REASON_CPU 3'h3
`define WPMS_REASON_SEC 3'h4
`define WPMS_REASON_DED 3'h5
`define WPMS_REASON_PIN 3'h6
`define WPMS_REASON_COMM 3'h7
`define WPMS_EXT_3V3 2'h2
`endif

// file: wpms_front_model.sv
// Far side model: supply, die temperature comparators and wake sources
`timescale 1ns/100ps
module wpms_front_model #(
  parameter [7:0] AL_RISE = 8'h7d,
  parameter [7:0] AL_FALL = 8'h73,
  parameter [7:0] SD_RISE = 8'h96,
  parameter [7:0] SD_FALL = 8'h8c
) (
  // Clock
  input wire clk_sys,
  // Bench controls
  input wire [7:0] temp,
  input wire pwr,
  input wire press,
  input wire charger,
  // Levels seen by the sequencer
  output reg supply_ok,
  output reg wake_input_n,
  output reg pack_above_startup,
  output reg temp_alert_hi,
  output reg temp_alert_lo,
  output reg temp_sd_hi,
  output reg temp_sd_lo
);
  initial begin
    {supply_ok, wake_input_n, pack_above_startup, temp_alert_hi, temp_alert_lo, temp_sd_hi,
      temp_sd_lo} = 7'h20;
  end
  always @(posedge clk_sys) begin
    supply_ok <= pwr;
    wake_input_n <= !press;
    pack_above_startup <= charger;
    temp_alert_hi <= temp >= AL_RISE;
    temp_alert_lo <= temp >= AL_FALL;
    temp_sd_hi <= temp >= SD_RISE;
    temp_sd_lo <= temp >= SD_FALL;
  end
endmodule // wpms_front_model

// file: wpms_top.v
// Wake, power mode and reset sequencer with APB register access
`timescale 1ns/100ps
`include "wpms_defs.vh"
module wpms_top #(
  parameter RST_CYC = (`WPMS_RST_TIME_US * `WPMS_CLK_MHZ),
  parameter POR_CYC = (`WPMS_RST_POR_US * `WPMS_CLK_MHZ),
  parameter SLOW_DIV = `WPMS_SLOW_DIV,
  parameter MIN_TICKS = `WPMS_MIN_TICKS
) (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Asynchronous wake and status inputs
  input wire wake_input_n,
  input wire pack_above_startup,
  input wire gpio_irq,
  input wire comm_irq,
  input wire rtc_event,
  input wire supply_ok,
  input wire temp_alert_hi,
  input wire temp_alert_lo,
  input wire temp_sd_hi,
  input wire temp_sd_lo,
  input wire reset_pin,
  // Same-domain MCU events
  input wire wdog_reset,
  input wire cpu_reset,
  input wire security_reset,
  input wire double_error_detect,
  input wire otp_io_fw_ctrl,
  // Power and reset outputs
  output reg core_regulator_en,
  output reg analog_regulator_en,
  output reg io_regulator_1v8,
  output reg [1:0] external_regulator_sel,
  output reg fast_oscillator_en,
  output reg afe_sleep,
  output reg slow_clk_mode,
  output reg cpu_run,
  output reg flash_on,
  output reg rom_on,
  output reg ram_on,
  output reg ram_retain,
  output reg mcu_reset,
  output reg fet_enable,
  output reg [1:0] pmu_mode
);
  localparam ST_OFF = 3'h0;
  localparam ST_AFE_RST = 3'h1;
  localparam ST_POR_HOLD = 3'h2;
  localparam ST_TRIM = 3'h3;
  localparam ST_ROM = 3'h4;
  localparam ST_INIT = 3'h5;
  localparam ST_ACTIVE = 3'h6;
  localparam ST_ALERT = 3'h7;
  localparam PM_RUN = 2'h0;
  localparam PM_STOP = 2'h1;
  localparam PM_STBY = 2'h2;
  localparam SM_NORMAL = 3'h0;
  localparam SM_SLEEP = 3'h1;
  localparam SM_DEEP = 3'h2;
  localparam SM_HIBER = 3'h3;
  localparam SM_SHELF = 3'h4;
  localparam SM_SHUT = 3'h5;
  reg [1:0] rst_sync_r;
  wire rst_n = rst_sync_r[1];
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  // Three-stage synchronisers, change accepted when stages two and three agree
  localparam NSYNC = 11;
  wire [NSYNC-1:0] async_in = {reset_pin, temp_sd_lo, temp_sd_hi, temp_alert_lo,
    temp_alert_hi, supply_ok, rtc_event, comm_irq, gpio_irq, pack_above_startup,
    ~wake_input_n};
  reg [NSYNC-1:0] s1_r, s2_r, s3_r, sv_r;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
          s3_r[gi] <= 1'b0;
          sv_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= async_in[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            sv_r[gi] <= s3_r[gi];
          end
        end
      end
    end
  endgenerate
  wire wake_pin = sv_r[0];
  wire pack_det = sv_r[1];
  wire any_irq = sv_r[2] | sv_r[3] | sv_r[4];
  wire sup_ok = sv_r[5];
  wire t_alert_hi = sv_r[6];
  wire t_alert_lo = sv_r[7];
  wire t_sd_hi = sv_r[8];
  wire t_sd_lo = sv_r[9];
  wire pin_rst = sv_r[10];
  // Registers
  reg [2:0] seq_r;
  reg [2:0] sys_mode_r;
  reg [31:0] cnt_r;
  reg thermal_sd_r;
  reg [2:0] reason_r;
  reg [31:0] user_r;
  reg [7:0] fault_r;
  reg host_rst_allow_r, pin_full_por_r, ded_en_r, io_flash_1v8_r;
  reg fw_flash_off_r, fw_ram_off_r, fw_rom_off_r, stop_flash_off_r;
  reg shelf_auto_r, woke_shelf_r, comm_rst_r;
  reg [15:0] shelf_min_r, min_cnt_r;
  reg [31:0] tick_cnt_r;
  reg [10:0] div_r;
  reg host_rst_req, mode_wr, por_req;
  reg [2:0] mode_req;
  wire slow_tick = (div_r == 11'h0);
  function [1:0] pm_of;
    input [2:0] sm;
    begin
      case (sm)
        SM_NORMAL: pm_of = PM_RUN;
        SM_SLEEP, SM_DEEP: pm_of = PM_STOP;
        default: pm_of = PM_STBY;
      endcase
    end
  endfunction
  wire apb_wr = psel & penable & pwrite;
  wire apb_rd = psel & penable & ~pwrite;
  wire mcu_evt = wdog_reset | cpu_reset | security_reset | (double_error_detect & ded_en_r);
  wire cold_wake = wake_pin | pack_det;
  wire pm_sleepy = (sys_mode_r == SM_SHELF) || (sys_mode_r == SM_SHUT);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 11'h0;
    end else if (slow_tick) begin
      div_r <= SLOW_DIV[10:0] - 11'h1;
    end else begin
      div_r <= div_r - 11'h1;
    end
  end

  // Reset and power-up sequencer
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seq_r <= ST_OFF;
      cnt_r <= 32'h0;
      thermal_sd_r <= 1'b0;
      sys_mode_r <= SM_NORMAL;
      reason_r <= 3'h0;
      fault_r <= 8'h0;
      user_r <= 32'h0;
      woke_shelf_r <= 1'b0;
      comm_rst_r <= 1'b0;
      min_cnt_r <= 16'h0;
      tick_cnt_r <= 32'h0;
    end else begin
      if (apb_wr && paddr == `WPMS_ADDR_USER) begin
        user_r <= pwdata;
      end
      if (seq_r != ST_OFF && seq_r != ST_AFE_RST) begin
        cnt_r <= cnt_r + 32'h1;
      end
      if (t_sd_hi) begin
        thermal_sd_r <= 1'b1;
        seq_r <= ST_OFF;
      end else if (!sup_ok && seq_r != ST_OFF) begin
        seq_r <= ST_OFF;
      end else begin
        case (seq_r)
          ST_OFF: begin
            if (thermal_sd_r) begin
              if (!t_sd_lo && !t_alert_lo) begin
                thermal_sd_r <= 1'b0;
                seq_r <= ST_AFE_RST;
                cnt_r <= 32'h0;
              end
            end else if (sys_mode_r != SM_SHUT && sys_mode_r != SM_SHELF) begin
              seq_r <= ST_AFE_RST;
              cnt_r <= 32'h0;
            end else if (cold_wake) begin
              woke_shelf_r <= (sys_mode_r == SM_SHELF);
              min_cnt_r <= 16'h0;
              tick_cnt_r <= 32'h0;
              sys_mode_r <= SM_NORMAL;
              seq_r <= ST_AFE_RST;
              cnt_r <= 32'h0;
            end
          end
          ST_AFE_RST: begin
            if (sup_ok) begin
              cnt_r <= cnt_r + 32'h1;
              if (cnt_r >= RST_CYC - 1) begin
                seq_r <= ST_POR_HOLD;
                cnt_r <= 32'h0;
                reason_r <= comm_rst_r ? `WPMS_REASON_COMM : `WPMS_REASON_POR;
                comm_rst_r <= 1'b0;
                fault_r <= comm_rst_r ? fault_r : 8'h0;
                user_r <= comm_rst_r ? user_r : 32'h0;
              end
            end else begin
              cnt_r <= 32'h0;
            end
          end
          ST_POR_HOLD: if (cnt_r >= POR_CYC - 1) begin
            seq_r <= ST_TRIM;
            cnt_r <= 32'h0;
          end
          ST_TRIM: if (cnt_r >= `WPMS_TRIM_CYC - 1) begin
            seq_r <= ST_ROM;
            cnt_r <= 32'h0;
          end
          ST_ROM: if (cnt_r >= `WPMS_ROM_CYC - 1) begin
            seq_r <= ST_INIT;
            cnt_r <= 32'h0;
          end
          ST_INIT: if (cnt_r >= 4 * `WPMS_STEP_CYC - 1) begin
            seq_r <= ST_ACTIVE;
          end
          ST_ACTIVE: begin
            if (t_alert_hi) begin
              seq_r <= ST_ALERT;
            end else if ((pin_rst && pin_full_por_r) || host_rst_req) begin
              seq_r <= ST_AFE_RST;
              cnt_r <= 32'h0;
              comm_rst_r <= host_rst_req;
            end else if (pin_rst || mcu_evt) begin
              seq_r <= ST_TRIM;
              cnt_r <= 32'h0;
              reason_r <= wdog_reset ? `WPMS_REASON_WDOG :
                cpu_reset ? `WPMS_REASON_CPU :
                security_reset ? `WPMS_REASON_SEC :
                pin_rst ? `WPMS_REASON_PIN : `WPMS_REASON_DED;
              fault_r <= fault_r + 8'h1;
            end else if (por_req) begin
              seq_r <= ST_OFF;
              sys_mode_r <= mode_req;
            end else if (mode_wr) begin
              sys_mode_r <= mode_req;
            end else if ((sys_mode_r != SM_NORMAL) && any_irq) begin
              sys_mode_r <= SM_NORMAL;
            end
            if (shelf_auto_r && woke_shelf_r && seq_r == ST_ACTIVE) begin
              if (slow_tick) begin
                if (tick_cnt_r >= MIN_TICKS - 1) begin
                  tick_cnt_r <= 32'h0;
                  min_cnt_r <= min_cnt_r + 16'h1;
                end else begin
                  tick_cnt_r <= tick_cnt_r + 32'h1;
                end
              end
              if (min_cnt_r >= shelf_min_r) begin
                sys_mode_r <= SM_SHELF;
                seq_r <= ST_OFF;
                woke_shelf_r <= 1'b0;
                min_cnt_r <= 16'h0;
              end
            end
          end
          ST_ALERT: if (t_alert_lo == 1'b0) begin
            seq_r <= ST_TRIM;
            cnt_r <= 32'h0;
          end
          default: seq_r <= ST_OFF;
        endcase
      end
    end
  end

  // Register writes
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      host_rst_allow_r <= 1'b0;
      pin_full_por_r <= 1'b0;
      ded_en_r <= 1'b0;
      io_flash_1v8_r <= 1'b0;
      fw_flash_off_r <= 1'b0;
      fw_ram_off_r <= 1'b0;
      fw_rom_off_r <= 1'b0;
      stop_flash_off_r <= 1'b1;
      shelf_auto_r <= 1'b0;
      shelf_min_r <= 16'h1;
      external_regulator_sel <= `WPMS_EXT_3V3;
      host_rst_req <= 1'b0;
      mode_wr <= 1'b0;
      por_req <= 1'b0;
      mode_req <= SM_NORMAL;
    end else begin
      host_rst_req <= 1'b0;
      mode_wr <= 1'b0;
      por_req <= 1'b0;
      if (apb_wr) begin
        case (paddr)
          `WPMS_ADDR_CTRL: begin
            host_rst_allow_r <= pwdata[0];
            pin_full_por_r <= pwdata[1];
            ded_en_r <= pwdata[2];
            fw_flash_off_r <= pwdata[3];
            fw_ram_off_r <= pwdata[4];
            fw_rom_off_r <= pwdata[5];
            stop_flash_off_r <= pwdata[6];
          end
          `WPMS_ADDR_MODE: begin
            mode_req <= (pwdata[2:0] > SM_SHUT) ? SM_NORMAL : pwdata[2:0];
            mode_wr <= 1'b1;
            por_req <= (pwdata[2:0] == SM_SHUT) || (pwdata[2:0] == SM_SHELF);
          end
          `WPMS_ADDR_RESET: host_rst_req <= pwdata[0] & host_rst_allow_r;
          `WPMS_ADDR_SHELF: begin
            shelf_auto_r <= pwdata[16];
            shelf_min_r <= pwdata[15:0];
          end
          `WPMS_ADDR_REGSEL: begin
            io_flash_1v8_r <= pwdata[2];
            external_regulator_sel <= pwdata[1:0];
          end
          default: ;
        endcase
      end
    end
  end

  // Outputs from the sequencer and power mode
  wire [1:0] pm = pm_of(sys_mode_r);
  wire up = (seq_r == ST_ACTIVE) || (seq_r == ST_INIT);
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      core_regulator_en <= 1'b0;
      analog_regulator_en <= 1'b0;
      io_regulator_1v8 <= 1'b0;
      fast_oscillator_en <= 1'b0;
      afe_sleep <= 1'b0;
      slow_clk_mode <= 1'b0;
      cpu_run <= 1'b0;
      flash_on <= 1'b0;
      rom_on <= 1'b0;
      ram_on <= 1'b0;
      ram_retain <= 1'b0;
      mcu_reset <= 1'b1;
      fet_enable <= 1'b0;
      pmu_mode <= PM_RUN;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      analog_regulator_en <= !t_sd_hi && !(thermal_sd_r && t_sd_lo) && (seq_r != ST_OFF || !pm_sleepy);
      core_regulator_en <= (seq_r != ST_OFF) && (seq_r != ST_AFE_RST) &&
        (seq_r != ST_ALERT) && !thermal_sd_r;
      mcu_reset <= !(seq_r == ST_ROM || up);
      io_regulator_1v8 <= otp_io_fw_ctrl & io_flash_1v8_r;
      pmu_mode <= pm;
      cpu_run <= up && pm == PM_RUN;
      afe_sleep <= pm == PM_STBY;
      slow_clk_mode <= pm == PM_STBY;
      fast_oscillator_en <= (seq_r != ST_OFF) && !(up && pm == PM_STBY);
      flash_on <= up && (pm == PM_RUN ? !fw_flash_off_r : pm == PM_STOP && !stop_flash_off_r);
      rom_on <= (seq_r == ST_ROM) || (up && (pm == PM_RUN ? !fw_rom_off_r :
        pm == PM_STOP && !stop_flash_off_r));
      ram_on <= up && pm == PM_RUN && !fw_ram_off_r;
      ram_retain <= (up && pm != PM_RUN) || pm == PM_STBY;
      fet_enable <= (seq_r == ST_ACTIVE) && !t_alert_hi;
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `WPMS_ADDR_CTRL: prdata <= {25'h0, stop_flash_off_r, fw_rom_off_r, fw_ram_off_r,
            fw_flash_off_r, ded_en_r, pin_full_por_r, host_rst_allow_r};
          `WPMS_ADDR_MODE: prdata <= {29'h0, sys_mode_r};
          `WPMS_ADDR_STATUS: prdata <= {22'h0, thermal_sd_r, woke_shelf_r, pm, 1'b0,
            seq_r, cold_wake, any_irq};
          `WPMS_ADDR_SHELF: prdata <= {15'h0, shelf_auto_r, shelf_min_r};
          `WPMS_ADDR_REASON: prdata <= {21'h0, fault_r, reason_r};
          `WPMS_ADDR_USER: prdata <= user_r;
          `WPMS_ADDR_REGSEL: prdata <= {29'h0, io_flash_1v8_r, external_regulator_sel};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end
endmodule // wpms_top

// file: wpms_top_tb.sv
// Self-checking bench for the wake, power mode and reset sequencer
`timescale 1ns/100ps
`include "wpms_defs.vh"
module wpms_top_tb;
  logic clk_sys = 1'h0;
  logic rstn = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, ostb = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, ov, sv, s;
  logic gpio_irq = 1'h0, comm_irq = 1'h0, rtc_event = 1'h0, reset_pin = 1'h0;
  logic wdog_reset = 1'h0, cpu_reset = 1'h0, security_reset = 1'h0, double_error_detect = 1'h0;
  logic otp_io_fw_ctrl = 1'h0, pwr = 1'h0, press = 1'h0, charger = 1'h0;
  logic [7:0] temp = 8'h19;
  wire [31:0] prdata;
  wire [1:0] external_regulator_sel, pmu_mode;
  wire pready, pslverr, core_regulator_en, analog_regulator_en, io_regulator_1v8;
  wire fast_oscillator_en, afe_sleep, slow_clk_mode, cpu_run, flash_on, rom_on, ram_on;
  wire ram_retain, mcu_reset, fet_enable, supply_ok, wake_input_n, pack_above_startup;
  wire temp_alert_hi, temp_alert_lo, temp_sd_hi, temp_sd_lo;
  logic [31:0] eq[$], mq[$];
  string nq[$];
  int err_total = 0, n_tests = 0, seed = 49, t;

  wpms_top #(.RST_CYC(8), .POR_CYC(16), .SLOW_DIV(4), .MIN_TICKS(10)) dut (
    .clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .wake_input_n, .pack_above_startup, .gpio_irq, .comm_irq, .rtc_event, .supply_ok,
    .temp_alert_hi, .temp_alert_lo, .temp_sd_hi, .temp_sd_lo, .reset_pin, .wdog_reset,
    .cpu_reset, .security_reset, .double_error_detect, .otp_io_fw_ctrl, .core_regulator_en,
    .analog_regulator_en, .io_regulator_1v8, .external_regulator_sel, .fast_oscillator_en,
    .afe_sleep, .slow_clk_mode, .cpu_run, .flash_on, .rom_on, .ram_on, .ram_retain,
    .mcu_reset, .fet_enable, .pmu_mode);
  wpms_front_model far (.clk_sys, .temp, .pwr, .press, .charger, .supply_ok, .wake_input_n,
    .pack_above_startup, .temp_alert_hi, .temp_alert_lo, .temp_sd_hi, .temp_sd_lo);

  always #12.5 clk_sys = ~clk_sys;

  // Result watcher: read completions and sampled port values
  always @(posedge clk_sys) begin
    if ((psel && penable && pready && !pwrite) || ostb) begin
      sv = (ostb ? ov : prdata) & mq[0];
      n_tests++;
      if (sv !== eq[0]) begin
        err_total++;
        $display("Error %s: expected %h, seen %h", nq[0], eq[0], sv);
      end
      void'(eq.pop_front());
      void'(mq.pop_front());
      void'(nq.pop_front());
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    cyc(2);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    nq.push_back(n);
    eq.push_back(e & m);
    mq.push_back(m);
    bus(1'h0, a, 32'h0);
  endtask
  task automatic chk(input string n, input logic [31:0] o, input logic [31:0] e);
    @(posedge clk_sys);
    nq.push_back(n);
    eq.push_back(e);
    mq.push_back(32'hffffffff);
    ov <= o;
    ostb <= 1'h1;
    @(posedge clk_sys);
    ostb <= 1'h0;
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return fet_enable;
      1: return mcu_reset;
      default: return pmu_mode == 2'h0;
    endcase
  endfunction
  task automatic wt(input int k, input logic v);
    int i;
    i = 0;
    while (pick(k) !== v && i < 4000) begin
      @(posedge clk_sys);
      i++;
    end
    t = i;
  endtask
  task automatic fin(input string n);
    $display("test %s done", n);
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_sys);
    err_total++;
    wrap_up;
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'h1;
    cyc(3);
    chk("mcu_reset", mcu_reset, 32'h1);
    chk("ext_sel", external_regulator_sel, `WPMS_EXT_3V3);
    pwr <= 1'h1;
    t = 0;
    while (mcu_reset !== 1'h0 && t < 4000) begin
      @(posedge clk_sys);
      t++;
    end
    chk("por_hold", t >= 32'h28, 32'h1);
    wt(0, 1'h1);
    chk("fet_on", fet_enable, 32'h1);
    fin("power_up");
    s = $random(seed);
    for (int k = 0; k < 4; k++) begin
      wr(`WPMS_ADDR_REGSEL, {30'h1, k[1:0] ^ s[1:0]});
      chk("ext_sel", external_regulator_sel, k[1:0] ^ s[1:0]);
    end
    rd("regsel", `WPMS_ADDR_REGSEL, {30'h1, ~s[1:0]}, 32'h7);
    chk("io_otp", io_regulator_1v8, 32'h0);
    otp_io_fw_ctrl <= 1'h1;
    cyc(8);
    chk("io_fw", io_regulator_1v8, 32'h1);
    rd("unmapped", 12'h020, 32'h0, 32'hffffffff);
    fin("regulators");
    for (int k = 1; k < 4; k++) begin
      wr(`WPMS_ADDR_MODE, k);
      cyc(40);
      chk("mode", pmu_mode, (k == 3) ? 32'h2 : 32'h1);
      chk("lowpwr", {afe_sleep, slow_clk_mode, cpu_run}, (k == 3) ? 32'h6 : 32'h0);
      {rtc_event, comm_irq, gpio_irq} <= 3'(1 << (k - 1));
      wt(2, 1'h1);
      chk("woken", {pmu_mode, cpu_run}, 32'h1);
      {rtc_event, comm_irq, gpio_irq} <= 3'h0;
      cyc(8);
    end
    wr(`WPMS_ADDR_CTRL, 32'h9);
    chk("flash_off", {flash_on, rom_on, ram_on}, 32'h3);
    fin("modes");
    s = $random(seed);
    wr(`WPMS_ADDR_USER, s);
    for (int k = 0; k < 4; k++) begin
      wt(0, 1'h1);
      wr(`WPMS_ADDR_CTRL, 32'h5);
      {double_error_detect, security_reset, cpu_reset, wdog_reset} <= 4'(1 << k);
      @(posedge clk_sys);
      {double_error_detect, security_reset, cpu_reset, wdog_reset} <= 4'h0;
      cyc(6);
      chk("mcu_rst", {mcu_reset, analog_regulator_en}, 32'h3);
      wt(1, 1'h0);
      rd("reason", `WPMS_ADDR_REASON, k + 2, 32'h7);
      rd("user", `WPMS_ADDR_USER, s, 32'hffffffff);
    end
    wt(0, 1'h1);
    reset_pin <= 1'h1;
    cyc(20);
    chk("pin_rst", mcu_reset, 32'h1);
    reset_pin <= 1'h0;
    wt(0, 1'h1);
    wr(`WPMS_ADDR_CTRL, 32'h0);
    wr(`WPMS_ADDR_RESET, 32'h1);
    cyc(4);
    chk("host_block", mcu_reset, 32'h0);
    wr(`WPMS_ADDR_CTRL, 32'h1);
    wr(`WPMS_ADDR_RESET, 32'h1);
    cyc(4);
    chk("host_rst", mcu_reset, 32'h1);
    wt(1, 1'h0);
    rd("reason", `WPMS_ADDR_REASON, 32'h7, 32'h7);
    fin("resets");
    wt(0, 1'h1);
    temp <= 8'h82;
    cyc(30);
    chk("alert", {mcu_reset, core_regulator_en, analog_regulator_en}, 32'h5);
    temp <= 8'h78;
    cyc(30);
    chk("alert_hys", {mcu_reset, core_regulator_en, analog_regulator_en}, 32'h5);
    temp <= 8'ha0;
    cyc(30);
    chk("tsd", {mcu_reset, core_regulator_en, analog_regulator_en}, 32'h4);
    temp <= 8'h91;
    cyc(60);
    chk("tsd_fall", {mcu_reset, core_regulator_en, analog_regulator_en}, 32'h4);
    temp <= 8'h78;
    cyc(30);
    chk("tsd_hold", {mcu_reset, core_regulator_en, analog_regulator_en}, 32'h5);
    temp <= 8'h64;
    wt(0, 1'h1);
    chk("restart", {mcu_reset, core_regulator_en, fet_enable}, 32'h3);
    fin("thermal");
    wr(`WPMS_ADDR_SHELF, 32'h1);
    for (int k = 0; k < 2; k++) begin
      wr(`WPMS_ADDR_MODE, 32'h5 - k);
      cyc(40);
      {rtc_event, comm_irq, gpio_irq} <= 3'h7;
      cyc(60);
      chk("stay_down", fet_enable, 32'h0);
      {rtc_event, comm_irq, gpio_irq} <= 3'h0;
      press <= (k == 0);
      charger <= (k == 1);
      wt(0, 1'h1);
      chk("wake", {fet_enable, mcu_reset}, 32'h2);
      press <= 1'h0;
      charger <= 1'h0;
    end
    wr(`WPMS_ADDR_SHELF, 32'h10008);
    wr(`WPMS_ADDR_MODE, 32'h4);
    cyc(40);
    press <= 1'h1;
    wt(0, 1'h1);
    press <= 1'h0;
    wt(0, 1'h0);
    chk("reshelf", fet_enable, 32'h0);
    chk("reshelf_time", t >= 300 && t < 360, 32'h1);
    rd("reshelf_mode", `WPMS_ADDR_MODE, 32'h4, 32'h7);
    fin("shutdown_shelf");
    wrap_up;
  end
endmodule // wpms_top_tb
